// *** core/lsm_regs.svh ***
// constants for the lane sample mapper: mode codes, lane enables, widths
`ifndef LSM_REGS_SVH
`define LSM_REGS_SVH

// lane configuration mode codes handled by the mapper
`define LSM_MODE_IQ_16L 8'h1B
`define LSM_MODE_BYP_SC 8'h20
`define LSM_MODE_BYP_DC 8'h21
`define LSM_MODE_ALT_A 8'h36
`define LSM_MODE_ALT_B 8'h3F

// active lanes per mode, bit 15..8 = b side lanes 7..0, bit 7..0 = a side lanes 7..0
`define LSM_LANE_EN_NONE 16'h0000
`define LSM_LANE_EN_IQ_16L 16'hFFFF
`define LSM_LANE_EN_BYP 16'h0707
`define LSM_LANE_EN_ALT 16'h0F0F

// field widths
`define LSM_LANES_PER_SIDE 8
`define LSM_SAMPLE_BITS 15
`define LSM_BYP_BITS 12
`define LSM_LANE_BITS 16
`define LSM_BYP_LANES 3
`define LSM_ALT_LANES 4

`endif

// *** core/lsm_pkg.sv ***
// types shared by the lane sample mapper files
package lsm_pkg;

   typedef logic [7:0] lsm_mode_t;

   // what the mapper does with the current frame, one-hot
   typedef enum logic [4:0] {
      LSM_MAP_NONE = 5'b00001,
      LSM_MAP_IQ16 = 5'b00010,
      LSM_MAP_IQ8 = 5'b00100,
      LSM_MAP_BYP_SC = 5'b01000,
      LSM_MAP_BYP_DC = 5'b10000
   } lsm_map_e;

   // one frame of converter samples; bypass modes use the low 12 bits of each word
   typedef struct packed {
      lsm_mode_t mode;
      logic [7:0][14:0] ch_a;
      logic [7:0][14:0] ch_b;
      logic [7:0] flag_a;
      logic [7:0] flag_b;
   } lsm_in_s;

   // one lane frame per lane; bits 15:8 are octet 0, bits 15:12 nibble 0
   typedef struct packed {
      logic [7:0][15:0] a_lane;
      logic [7:0][15:0] b_lane;
      logic [15:0] lane_en;
      logic mode_err;
   } lsm_out_s;

endpackage

// *** core/lsm_skid_buf.sv ***
// two-entry buffer between the mapper and the lane receiver
`timescale 1ns/1ns
module lsm_skid_buf (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire lsm_pkg::lsm_out_s in_data,
   input wire logic in_valid,
   output logic in_ready,
   output lsm_pkg::lsm_out_s out_data,
   output logic out_valid,
   input wire logic out_ready
);

   lsm_pkg::lsm_out_s main_ff;
   lsm_pkg::lsm_out_s nxt_main_ff;
   lsm_pkg::lsm_out_s skid_ff;
   lsm_pkg::lsm_out_s nxt_skid_ff;
   logic main_valid_ff;
   logic nxt_main_valid_ff;
   logic skid_valid_ff;
   logic nxt_skid_valid_ff;
   logic ready_ff;
   logic nxt_ready_ff;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////
   // the head entry drives the outputs directly; the skid entry catches the word
   // that was accepted in the cycle the receiver stalled, so nothing is dropped
   always_comb begin
      push = in_valid & ready_ff;
      pop = main_valid_ff & out_ready;
      nxt_main_ff = main_ff;
      nxt_skid_ff = skid_ff;
      nxt_main_valid_ff = main_valid_ff;
      nxt_skid_valid_ff = skid_valid_ff;
      if (pop) begin
         if (skid_valid_ff) begin
            // ready was low, so no push can coincide here
            nxt_main_ff = skid_ff;
            nxt_skid_valid_ff = 1'b0;
         end else if (push) begin
            nxt_main_ff = in_data;
         end else begin
            nxt_main_valid_ff = 1'b0;
         end
      end else if (push) begin
         if (!main_valid_ff) begin
            nxt_main_ff = in_data;
            nxt_main_valid_ff = 1'b1;
         end else begin
            nxt_skid_ff = in_data;
            nxt_skid_valid_ff = 1'b1;
         end
      end
      // ready is registered from the next skid state, so it reopens on the same edge the skid drains
      nxt_ready_ff = ~nxt_skid_valid_ff;
   end

   // storage
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         main_ff <= '0;
         skid_ff <= '0;
         main_valid_ff <= 1'b0;
         skid_valid_ff <= 1'b0;
         ready_ff <= 1'b1;
      end else begin
         main_ff <= nxt_main_ff;
         skid_ff <= nxt_skid_ff;
         main_valid_ff <= nxt_main_valid_ff;
         skid_valid_ff <= nxt_skid_valid_ff;
         ready_ff <= nxt_ready_ff;
      end
   end

   assign out_data = main_ff;
   assign out_valid = main_valid_ff;
   assign in_ready = ready_ff;

endmodule

// *** core/lsm_mapper.sv ***
// lane sample mapper: places one frame of samples onto the a and b side lanes
`timescale 1ns/1ns
`include "lsm_regs.svh"
module lsm_mapper (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire lsm_pkg::lsm_in_s in_data,
   input wire logic in_valid,
   output logic in_ready,
   output lsm_pkg::lsm_out_s out_data,
   output logic out_valid,
   input wire logic out_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   lsm_pkg::lsm_map_e map_kind;
   lsm_pkg::lsm_out_s mapped;
   logic [`LSM_LANES_PER_SIDE-1:0][`LSM_LANE_BITS-1:0] iq_a;
   logic [`LSM_LANES_PER_SIDE-1:0][`LSM_LANE_BITS-1:0] iq_b;
   logic [`LSM_BYP_LANES-1:0][`LSM_LANE_BITS-1:0] byp_sc_a;
   logic [`LSM_BYP_LANES-1:0][`LSM_LANE_BITS-1:0] byp_sc_b;
   logic [`LSM_BYP_LANES-1:0][`LSM_LANE_BITS-1:0] byp_dc_a;
   logic [`LSM_BYP_LANES-1:0][`LSM_LANE_BITS-1:0] byp_dc_b;
   logic [47:0] pack_sc_a;
   logic [47:0] pack_sc_b;
   logic [47:0] pack_dc_a;
   logic [47:0] pack_dc_b;

   ////////////////////////////////////////////////////////////////////////////
   // four 12-bit samples, msbs first, form a 48-bit run that fills three lanes;
   // this yields the 4/8 and 8/4 splits across lane boundaries by itself
   function automatic logic [47:0] pack4(
      input logic [11:0] s0,
      input logic [11:0] s1,
      input logic [11:0] s2,
      input logic [11:0] s3
   );
      pack4 = {s0, s1, s2, s3};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // mode decode; unknown codes map nothing and raise the error flag
   always_comb begin
      map_kind = lsm_pkg::LSM_MAP_NONE;
      if (in_data.mode == `LSM_MODE_IQ_16L) begin
         map_kind = lsm_pkg::LSM_MAP_IQ16;
      end else if (in_data.mode == `LSM_MODE_BYP_SC) begin
         map_kind = lsm_pkg::LSM_MAP_BYP_SC;
      end else if (in_data.mode == `LSM_MODE_BYP_DC) begin
         map_kind = lsm_pkg::LSM_MAP_BYP_DC;
      end else if (in_data.mode == `LSM_MODE_ALT_A || in_data.mode == `LSM_MODE_ALT_B) begin
         map_kind = lsm_pkg::LSM_MAP_IQ8;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-lane word with its over-range flag in the lsb; word msb lands in nibble 0
   generate
      for (genvar k = 0; k < `LSM_LANES_PER_SIDE; k++) begin : g_iq
         assign iq_a[k] = {in_data.ch_a[k], in_data.flag_a[k]};
         assign iq_b[k] = {in_data.ch_b[k], in_data.flag_b[k]};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // bypass packing; single channel sends s[0..7] on ch_a, even to a, odd to b
   assign pack_sc_a = pack4(in_data.ch_a[0][11:0], in_data.ch_a[2][11:0],
                            in_data.ch_a[4][11:0], in_data.ch_a[6][11:0]);
   assign pack_sc_b = pack4(in_data.ch_a[1][11:0], in_data.ch_a[3][11:0],
                            in_data.ch_a[5][11:0], in_data.ch_a[7][11:0]);
   // dual channel takes four consecutive samples of each channel
   assign pack_dc_a = pack4(in_data.ch_a[0][11:0], in_data.ch_a[1][11:0],
                            in_data.ch_a[2][11:0], in_data.ch_a[3][11:0]);
   assign pack_dc_b = pack4(in_data.ch_b[0][11:0], in_data.ch_b[1][11:0],
                            in_data.ch_b[2][11:0], in_data.ch_b[3][11:0]);

   // lane j takes the j-th 16-bit slice from the top, so octet 0 is sent first
   generate
      for (genvar j = 0; j < `LSM_BYP_LANES; j++) begin : g_byp
         assign byp_sc_a[j] = pack_sc_a[47-16*j -: 16];
         assign byp_sc_b[j] = pack_sc_b[47-16*j -: 16];
         assign byp_dc_a[j] = pack_dc_a[47-16*j -: 16];
         assign byp_dc_b[j] = pack_dc_b[47-16*j -: 16];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // lane selection; unused lanes carry zero so a receiver never sees stale data
   always_comb begin
      mapped = '0;
      unique case (map_kind)
         lsm_pkg::LSM_MAP_NONE: begin
            mapped.lane_en = `LSM_LANE_EN_NONE;
            mapped.mode_err = 1'b1;
         end
         lsm_pkg::LSM_MAP_IQ16: begin
            mapped.a_lane = iq_a;
            mapped.b_lane = iq_b;
            mapped.lane_en = `LSM_LANE_EN_IQ_16L;
         end
         lsm_pkg::LSM_MAP_IQ8: begin
            // the earlier table carries I/Q words on four lanes a side
            for (int k = 0; k < `LSM_ALT_LANES; k++) begin
               mapped.a_lane[k] = iq_a[k];
               mapped.b_lane[k] = iq_b[k];
            end
            mapped.lane_en = `LSM_LANE_EN_ALT;
         end
         lsm_pkg::LSM_MAP_BYP_SC: begin
            for (int j = 0; j < `LSM_BYP_LANES; j++) begin
               mapped.a_lane[j] = byp_sc_a[j];
               mapped.b_lane[j] = byp_sc_b[j];
            end
            mapped.lane_en = `LSM_LANE_EN_BYP;
         end
         lsm_pkg::LSM_MAP_BYP_DC: begin
            for (int j = 0; j < `LSM_BYP_LANES; j++) begin
               mapped.a_lane[j] = byp_dc_a[j];
               mapped.b_lane[j] = byp_dc_b[j];
            end
            mapped.lane_en = `LSM_LANE_EN_BYP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // output buffer: all outputs come from its flops; a receiver stall backs up
   // into in_ready so the sample source holds its frame instead of losing it
   lsm_skid_buf u_buf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_data(mapped),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .out_data(out_data),
      .out_valid(out_valid),
      .out_ready(out_ready)
   );

endmodule

// *** sim/lsm_checker.sv ***
// port assertions for the lane sample mapper
`timescale 1ns/1ns
module lsm_checker (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire lsm_pkg::lsm_in_s in_data,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire lsm_pkg::lsm_out_s out_data,
   input wire logic out_valid,
   input wire logic out_ready
);
   lsm_pkg::lsm_in_s f_ff;
   logic new_ff;
   wire [47:0] oa = {out_data.a_lane[0], out_data.a_lane[1], out_data.a_lane[2]};
   wire [47:0] ob = {out_data.b_lane[0], out_data.b_lane[1], out_data.b_lane[2]};
   // a frame taken into an empty path must show on the very next cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         new_ff <= 1'b0;
         f_ff <= '0;
      end else begin
         new_ff <= in_valid && in_ready && !out_valid;
         f_ff <= in_data;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////
   iq_a_a: assert property (new_ff && f_ff.mode == 8'h1B |-> out_valid &&
      out_data.a_lane[5] == {f_ff.ch_a[5], f_ff.flag_a[5]}) else $error("iq a lane wrong");
   iq_b_a: assert property (new_ff && f_ff.mode == 8'h1B |->
      out_data.b_lane[7] == {f_ff.ch_b[7], f_ff.flag_b[7]}) else $error("iq b lane wrong");
   sc_even_a: assert property (new_ff && f_ff.mode == 8'h20 |-> oa ==
      {f_ff.ch_a[0][11:0], f_ff.ch_a[2][11:0], f_ff.ch_a[4][11:0], f_ff.ch_a[6][11:0]})
      else $error("single bypass a lanes wrong");
   sc_odd_a: assert property (new_ff && f_ff.mode == 8'h20 |-> ob ==
      {f_ff.ch_a[1][11:0], f_ff.ch_a[3][11:0], f_ff.ch_a[5][11:0], f_ff.ch_a[7][11:0]})
      else $error("single bypass b lanes wrong");
   dc_a_a: assert property (new_ff && f_ff.mode == 8'h21 |-> oa ==
      {f_ff.ch_a[0][11:0], f_ff.ch_a[1][11:0], f_ff.ch_a[2][11:0], f_ff.ch_a[3][11:0]})
      else $error("dual bypass a lanes wrong");
   dc_b_a: assert property (new_ff && f_ff.mode == 8'h21 |-> ob ==
      {f_ff.ch_b[0][11:0], f_ff.ch_b[1][11:0], f_ff.ch_b[2][11:0], f_ff.ch_b[3][11:0]})
      else $error("dual bypass b lanes wrong");
   alt_map_a: assert property (new_ff && f_ff.mode inside {8'h36, 8'h3F} |->
      out_data.lane_en == 16'h0F0F && out_data.a_lane[3] == {f_ff.ch_a[3], f_ff.flag_a[3]})
      else $error("alternate mode lanes wrong");
   stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output moved while stalled");
   bad_mode_a: assert property (out_valid && out_data.mode_err |-> out_data.lane_en == 16'h0000)
      else $error("lanes enabled on bad mode");
   iq_seen_c: cover property (new_ff && f_ff.mode == 8'h1B);
   full_c: cover property (out_valid && !out_ready ##1 !in_ready);
   err_c: cover property (out_valid && out_data.mode_err);
endmodule

// *** sim/lsm_lane_rx.sv ***
// lane receiver model: takes frames when ready, may stall on request
`timescale 1ns/1ns
module lsm_lane_rx (
   input wire logic clk_sys,
   input wire logic stall,
   input wire lsm_pkg::lsm_out_s out_data,
   input wire logic out_valid,
   output logic out_ready
);
   lsm_pkg::lsm_out_s q[$];
   initial out_ready = 1'b0;
   // ready moves just after the edge, so a stall lasts whole cycles
   always @(posedge clk_sys) out_ready <= !stall;
   // a frame counts only at an edge where both sides agree; lanes kept whole
   always @(posedge clk_sys) if (out_valid && out_ready) q.push_back(out_data);
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the lane sample mapper
`timescale 1ns/1ns
module testbench;
   logic clk_sys = 1'b0;
   logic rst_b, in_valid, in_ready, out_valid, out_ready, stall;
   lsm_pkg::lsm_in_s in_data;
   lsm_pkg::lsm_out_s out_data;
   int fail_count = 0;
   int n_tests = 0;
   always #10 clk_sys = ~clk_sys;
   lsm_mapper lsm_mapper_inst (.clk_sys(clk_sys), .rst_b(rst_b), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
      .out_valid(out_valid), .out_ready(out_ready));
   lsm_lane_rx lsm_lane_rx_inst (.clk_sys(clk_sys), .stall(stall), .out_data(out_data),
      .out_valid(out_valid), .out_ready(out_ready));
   ////////////////////////////////////////////////////////////////
   // frame with distinct words; top bits set so bypass must drop them
   function automatic lsm_pkg::lsm_in_s mk(logic [7:0] m);
      lsm_pkg::lsm_in_s f;
      f.mode = m;
      for (int k = 0; k < 8; k++) begin
         f.ch_a[k] = 15'h5A3C ^ (15'(k) * 15'h0929);
         f.ch_b[k] = 15'h6C1E ^ (15'(k) * 15'h1105);
      end
      f.flag_a = 8'hA5;
      f.flag_b = 8'h3C;
      return f;
   endfunction
   // lanes worked out by hand: msb first, octet 0 in bits 15:8
   function automatic lsm_pkg::lsm_out_s exp_of(lsm_pkg::lsm_in_s f);
      lsm_pkg::lsm_out_s e;
      e = '0;
      case (f.mode)
         8'h1B, 8'h36, 8'h3F: begin
            e.lane_en = (f.mode == 8'h1B) ? 16'hFFFF : 16'h0F0F;
            for (int k = 0; k < 8; k++) begin
               if (f.mode == 8'h1B || k < 4) begin
                  e.a_lane[k] = {f.ch_a[k], f.flag_a[k]};
                  e.b_lane[k] = {f.ch_b[k], f.flag_b[k]};
               end
            end
         end
         8'h20, 8'h21: begin
            e.lane_en = 16'h0707;
            {e.a_lane[0], e.a_lane[1], e.a_lane[2]} = (f.mode == 8'h20) ?
               {f.ch_a[0][11:0], f.ch_a[2][11:0], f.ch_a[4][11:0], f.ch_a[6][11:0]} :
               {f.ch_a[0][11:0], f.ch_a[1][11:0], f.ch_a[2][11:0], f.ch_a[3][11:0]};
            {e.b_lane[0], e.b_lane[1], e.b_lane[2]} = (f.mode == 8'h20) ?
               {f.ch_a[1][11:0], f.ch_a[3][11:0], f.ch_a[5][11:0], f.ch_a[7][11:0]} :
               {f.ch_b[0][11:0], f.ch_b[1][11:0], f.ch_b[2][11:0], f.ch_b[3][11:0]};
         end
         default: e.mode_err = 1'b1;
      endcase
      return e;
   endfunction
   task automatic chk_out(lsm_pkg::lsm_out_s g, lsm_pkg::lsm_out_s e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t lane frame mismatch", $time);
      end
   endtask
   task automatic chk_bit(logic g, logic e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t flag mismatch", $time);
      end
   endtask
   // valid stays up after the taking edge; the caller lowers it
   task automatic send(lsm_pkg::lsm_in_s f);
      in_data = f;
      in_valid = 1'b1;
      for (int i = 0; i < 50 && in_ready !== 1'b1; i++) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic recv(lsm_pkg::lsm_out_s e);
      lsm_pkg::lsm_out_s g;
      for (int i = 0; i < 50 && lsm_lane_rx_inst.q.size() == 0; i++) @(negedge clk_sys);
      g = '1;
      if (lsm_lane_rx_inst.q.size() > 0) g = lsm_lane_rx_inst.q.pop_front();
      chk_out(g, e);
   endtask
   task automatic run(logic [7:0] m);
      send(mk(m));
      in_valid = 1'b0;
      recv(exp_of(mk(m)));
   endtask
   task automatic t_modes();
      run(8'h1B);
      run(8'h20);
      run(8'h21);
      run(8'h36);
      run(8'h3F);
      run(8'h00);
      $display("test modes done");
   endtask
   // receiver stalls: second frame fills the buffer, nothing may be lost
   task automatic t_stall();
      stall = 1'b1;
      @(negedge clk_sys);
      send(mk(8'h20));
      send(mk(8'h21));
      in_valid = 1'b0;
      chk_bit(in_ready, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk_bit(in_ready, 1'b0);
      stall = 1'b0;
      recv(exp_of(mk(8'h20)));
      recv(exp_of(mk(8'h21)));
      $display("test stall done");
   endtask
   // reset with a full buffer: both frames are dropped and nothing leaks out afterwards
   task automatic t_reset();
      stall = 1'b1;
      @(negedge clk_sys);
      send(mk(8'h1B));
      send(mk(8'h20));
      in_valid = 1'b0;
      rst_b = 1'b0;
      @(negedge clk_sys);
      chk_bit(out_valid, 1'b0);
      chk_bit(in_ready, 1'b1);
      chk_out(out_data, '0);
      rst_b = 1'b1;
      stall = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk_bit(out_valid, 1'b0);
      chk_bit(lsm_lane_rx_inst.q.size() == 0, 1'b1);
      run(8'h21);
      $display("test reset done");
   endtask
   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      in_valid = 1'b0;
      in_data = '0;
      stall = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      t_modes();
      t_stall();
      t_reset();
      summarize();
   end
   // the tests need well under a hundred cycles; this allows 4000 cycles
   initial begin
      #(20 * 4000);
      fail_count++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      summarize();
   end
endmodule
bind lsm_mapper lsm_checker lsm_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
   .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
   .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
